// ===== pkg/sspi_port_pkg.sv
package sspi_port_pkg;

    // Link-side constants
    localparam logic [31:0] ACTIVATION_KEY   = 32'hA4C6_F48A;
    localparam logic [31:0] CMD_DUAL_ENABLE  = 32'hD9B3_3EB3;
    localparam logic [31:0] CMD_QUAD_ENABLE  = 32'hD9B3_3EBD;
    // Disable code kept exactly as printed (28 significant bits)
    localparam logic [31:0] CMD_WIDE_DISABLE = 32'h0D9F_FFFF;
    localparam int          WORD_BITS        = 32;
    localparam int          BYTE_BITS        = 8;
    localparam logic [5:0]  SERIAL_CMD_BITS  = 6'h20;

    // Timing on clk_sys (40 MHz)
    localparam int  SYS_CLK_KHZ          = 40000;
    localparam int  PROGRAM_PULSE_MIN_NS = 50;
    localparam int  PROGRAM_PULSE_MIN_CYC =
        (PROGRAM_PULSE_MIN_NS * SYS_CLK_KHZ + 999_999) / 1_000_000;
    localparam int  STATUS_WAIT_PLAIN_US = 60;
    localparam int  STATUS_WAIT_PLAIN_CYC = STATUS_WAIT_PLAIN_US * SYS_CLK_KHZ / 1000;
    localparam int  STATUS_WAIT_ENC_US   = 102060;
    localparam int  STATUS_WAIT_ENC_CYC  = STATUS_WAIT_ENC_US * (SYS_CLK_KHZ / 1000);

    // Reset values
    localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        WIDTH_X1,
        WIDTH_X2,
        WIDTH_X4
    } width_t;

    typedef enum logic [2:0] {
        CFG_WAIT_INIT,
        CFG_LOADING,
        CFG_AUTH_WAIT,
        CFG_SET_DONE,
        CFG_WAKE_HOLD,
        CFG_USER
    } cfg_state_t;

    // Wide data lines, three signals per line
    typedef struct packed {
        logic [3:0] dataIn;
        logic [3:0] dataOut;
        logic [3:0] dataOe;
    } wide_lines_t;

    // Persistence bits carried in the bitstream
    typedef struct packed {
        logic   keepPort;
        width_t keepWidth;
    } persist_t;

    // Configuration status seen by the host side
    typedef struct packed {
        logic portActive;
        logic configDone;
        logic authenticationComplete;
        logic userMode;
        logic transparent;
        logic pinsReserved;
    } cfg_status_t;

endpackage

// ===== rtl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    logic stage1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// ===== rtl/sspi_link_shift.sv
`timescale 1ns/1ps
module sspi_link_shift
    import sspi_port_pkg::*;
(
    // Link clock, reset and deselect
    input  wire logic       sclk,
    input  wire logic       rst,
    input  wire logic       port_select_n,
    // Data lines
    input  wire logic [3:0] lineIn,
    input  wire sspi_port_pkg::width_t width,
    // Shift state
    output logic [31:0]     shiftWord,
    output logic [5:0]      bitCount,
    output logic            byteToggle,
    output logic [31:0]     byteWord
);
    logic [31:0] next_shift;
    logic [5:0]  step;
    logic [2:0]  inByte;
    logic [3:0]  stepByte;

    always_comb begin
        next_shift = shiftWord;
        step       = 6'd1;
        case (width)
            WIDTH_X2: begin
                next_shift = {shiftWord[29:0], lineIn[1:0]};
                step       = 6'd2;
            end
            WIDTH_X4: begin
                next_shift = {shiftWord[27:0], lineIn[3:0]};
                step       = 6'd4;
            end
            default: next_shift = {shiftWord[30:0], lineIn[0]};
        endcase
        stepByte = {1'b0, inByte} + {1'b0, step[2:0]};
    end

    // Sample on rising SCLK; chip-select high clears count
    always_ff @(posedge sclk or posedge port_select_n) begin
        if (port_select_n) begin
            shiftWord <= SHIFT_RESET;
            bitCount  <= 6'd0;
            inByte    <= 3'd0;
        end else begin
            shiftWord <= next_shift;
            if (bitCount < 6'd40) begin
                bitCount <= bitCount + step;
            end
            inByte <= stepByte[2:0];
        end
    end

    // Word toggled out per whole byte, held past deselect
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            byteToggle <= 1'b0;
            byteWord   <= SHIFT_RESET;
        end else if (!port_select_n && stepByte[3]) begin
            byteToggle <= ~byteToggle;
            byteWord   <= next_shift;
        end
    end
endmodule

// ===== rtl/slave_spi_config_port.sv
`timescale 1ns/1ps
module slave_spi_config_port
(
    // System clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    // Link pins
    input  wire logic                       sclk,
    input  wire logic                       port_select_n,
    input  wire logic [3:0]                 wideDataIn,
    output logic [3:0]                      wideDataOut,
    output logic [3:0]                      wideDataOe,
    // Configuration pins
    input  wire logic                       program_request_n,
    output logic                            config_init_status,
    input  wire logic                       donePinIn,
    output logic                            donePinOe,
    // Configuration engine
    input  wire logic                       bitstreamComplete,
    input  wire logic                       encryptedStream,
    input  wire logic                       authPass,
    input  wire logic                       reloadRequest,
    input  wire logic                       readCommand,
    input  wire logic [7:0]                 readData,
    input  wire sspi_port_pkg::persist_t    persistBits,
    // Status
    output sspi_port_pkg::cfg_status_t      status,
    output sspi_port_pkg::width_t           portWidth,
    output logic                            keySeen
);
    import sspi_port_pkg::*;

    cfg_state_t  cfgState;
    width_t      width;
    width_t      widthSclk;
    width_t      pendingWidth;
    logic [31:0] shiftWord;
    logic [5:0]  bitCount;
    logic        byteToggle;
    logic [31:0] byteWord;
    logic        portActive;
    logic        configDone;
    logic        authDone;
    logic        userMode;
    logic        persisted;
    logic        progSync;
    logic [3:0]  syncIn;
    logic [3:0]  syncOut;
    logic [31:0] frameWord;
    logic        doneSync;
    logic        selSync;
    logic        selPrev;
    logic        togSync;
    logic        togPrev;
    logic        readSclk;
    logic        readMeta;
    logic        widthChange;
    logic        clearWide;
    logic [15:0] progLowCount;
    logic        progPulse;
    logic [31:0] waitCount;
    logic [7:0]  outShift;
    logic [2:0]  outBit;

    sspi_link_shift u_shift (
        .sclk          (sclk),
        .rst           (sys_rst),
        .port_select_n (port_select_n),
        .lineIn        (wideDataIn),
        .width         (widthSclk),
        .shiftWord     (shiftWord),
        .bitCount      (bitCount),
        .byteToggle    (byteToggle),
        .byteWord      (byteWord)
    );

    assign syncIn = {byteToggle, port_select_n, donePinIn, program_request_n};
    assign {togSync, selSync, doneSync, progSync} = syncOut;

    for (genvar g = 0; g < 4; g++) begin : g_sync
        bit_sync u_sync (
            .clk  (clk_sys),
            .rst  (sys_rst),
            .din  (syncIn[g]),
            .dout (syncOut[g])
        );
    end

    // Edge history in the system domain
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            selPrev  <= 1'b1;
            togPrev  <= 1'b0;
        end else begin
            selPrev  <= selSync;
            togPrev  <= togSync;
        end
    end

    // Qualified program-request pulse, once per low period
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            progLowCount <= 16'h0000;
            progPulse    <= 1'b0;
        end else begin
            progPulse <= 1'b0;
            if (progSync) begin
                progLowCount <= 16'h0000;
            end else if (progLowCount < 16'(PROGRAM_PULSE_MIN_CYC)) begin
                progLowCount <= progLowCount + 16'h0001;
                progPulse    <= (progLowCount == 16'(PROGRAM_PULSE_MIN_CYC - 1));
            end
        end
    end

    // Whole-byte key check on the latest 32 bits
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            portActive <= 1'b0;
        end else if (progPulse || reloadRequest) begin
            portActive <= 1'b0;
        end else if ((togSync != togPrev) && byteWord == ACTIVATION_KEY
                     && config_init_status && !userMode) begin
            portActive <= 1'b1;
        end
    end

    // Word as it stands once this edge's bits are in
    always_comb begin
        case (widthSclk)
            WIDTH_X2: frameWord = {shiftWord[29:0], wideDataIn[1:0]};
            WIDTH_X4: frameWord = {shiftWord[27:0], wideDataIn};
            default:  frameWord = {shiftWord[30:0], wideDataIn[0]};
        endcase
    end

    // Decode held from the 32nd bit until the next frame starts
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            pendingWidth <= WIDTH_X1;
            clearWide    <= 1'b0;
            widthChange  <= 1'b0;
        end else if (!port_select_n) begin
            if (bitCount == 6'd0) begin
                widthChange <= 1'b0;
                clearWide   <= 1'b0;
            end
            // Enable must be exactly the first 32 serial bits
            if (bitCount == SERIAL_CMD_BITS - 6'd1 && widthSclk == WIDTH_X1) begin
                if (frameWord == CMD_DUAL_ENABLE) begin
                    pendingWidth <= WIDTH_X2;
                    widthChange  <= 1'b1;
                end else if (frameWord == CMD_QUAD_ENABLE) begin
                    pendingWidth <= WIDTH_X4;
                    widthChange  <= 1'b1;
                end
            end
            if (bitCount == SERIAL_CMD_BITS - 6'(widthSclk == WIDTH_X4 ? 4 :
                                               widthSclk == WIDTH_X2 ? 2 : 1)) begin
                clearWide <= (frameWord[27:0] == CMD_WIDE_DISABLE[27:0]);
            end
        end
    end

    // Applied on synced deselect; link decode stands still then
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            width <= WIDTH_X1;
        end else if (progPulse || reloadRequest) begin
            width <= WIDTH_X1;
        end else if (selSync && !selPrev) begin
            if (clearWide) begin
                width <= WIDTH_X1;
            end else if (widthChange && width == WIDTH_X1) begin
                width <= pendingWidth;
            end
        end
    end

    // Width handed to the link domain; changes only while deselected
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            widthSclk <= WIDTH_X1;
        end else if (port_select_n) begin
            widthSclk <= width;
        end
    end

    // Configuration flow and wake-up
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfgState   <= CFG_WAIT_INIT;
            configDone <= 1'b0;
            authDone   <= 1'b0;
            userMode   <= 1'b0;
            persisted  <= 1'b0;
            waitCount  <= 32'h0000_0000;
        end else if (progPulse || reloadRequest) begin
            cfgState   <= CFG_WAIT_INIT;
            configDone <= 1'b0;
            authDone   <= 1'b0;
            userMode   <= 1'b0;
            persisted  <= 1'b0;
        end else begin
            case (cfgState)
                CFG_WAIT_INIT: begin
                    if (progSync) begin
                        cfgState <= CFG_LOADING;
                    end
                end
                CFG_LOADING: begin
                    if (bitstreamComplete) begin
                        waitCount <= encryptedStream ? 32'(STATUS_WAIT_ENC_CYC)
                                                     : 32'(STATUS_WAIT_PLAIN_CYC);
                        cfgState  <= CFG_AUTH_WAIT;
                    end
                end
                CFG_AUTH_WAIT: begin
                    if (waitCount != 32'h0000_0000) begin
                        waitCount <= waitCount - 32'h0000_0001;
                    end else if (!encryptedStream || authPass) begin
                        cfgState <= CFG_SET_DONE;
                    end
                end
                CFG_SET_DONE: begin
                    configDone <= 1'b1;
                    authDone   <= encryptedStream;
                    cfgState   <= CFG_WAKE_HOLD;
                end
                CFG_WAKE_HOLD: begin
                    if (doneSync) begin
                        userMode  <= 1'b1;
                        persisted <= persistBits.keepPort;
                        cfgState  <= CFG_USER;
                    end
                end
                CFG_USER: begin
                    cfgState <= CFG_USER;
                end
                default: cfgState <= CFG_WAIT_INIT;
            endcase
        end
    end

    // Read enable crossed into the link domain by two flops
    always_ff @(posedge sclk or posedge port_select_n) begin
        if (port_select_n) begin
            readMeta <= 1'b0;
            readSclk <= 1'b0;
        end else begin
            readMeta <= readCommand && (!userMode || (persisted && doneSync
                        && config_init_status));
            readSclk <= readMeta;
        end
    end

    // Output shifted on falling SCLK, MSB first
    always_ff @(negedge sclk or posedge port_select_n) begin
        if (port_select_n) begin
            outShift    <= 8'h00;
            outBit      <= 3'd0;
            wideDataOut <= 4'h0;
            wideDataOe  <= 4'h0;
        end else if (!readSclk) begin
            wideDataOe <= 4'h0;
            outBit     <= 3'd0;
        end else begin
            if (outBit == 3'd0) begin
                outShift <= readData;
            end
            case (widthSclk)
                WIDTH_X2: begin
                    wideDataOut <= {2'b00, (outBit == 3'd0 ? readData[7:6] : outShift[7:6])};
                    wideDataOe  <= 4'h3;
                    outShift    <= (outBit == 3'd0 ? readData : outShift) << 2;
                    outBit      <= (outBit == 3'd3) ? 3'd0 : outBit + 3'd1;
                end
                WIDTH_X4: begin
                    wideDataOut <= (outBit == 3'd0 ? readData[7:4] : outShift[7:4]);
                    wideDataOe  <= 4'hF;
                    outShift    <= (outBit == 3'd0 ? readData : outShift) << 4;
                    outBit      <= (outBit == 3'd1) ? 3'd0 : outBit + 3'd1;
                end
                default: begin
                    wideDataOut <= {2'b00, (outBit == 3'd0 ? readData[7] : outShift[7]), 1'b0};
                    wideDataOe  <= 4'h2;
                    outShift    <= (outBit == 3'd0 ? readData : outShift) << 1;
                    outBit      <= outBit + 3'd1;
                end
            endcase
        end
    end

    // Registered status outputs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            config_init_status <= 1'b0;
            donePinOe          <= 1'b1;
            status             <= '0;
            portWidth          <= WIDTH_X1;
            keySeen            <= 1'b0;
        end else begin
            config_init_status <= (cfgState != CFG_WAIT_INIT);
            donePinOe          <= !configDone;
            status.portActive  <= portActive;
            status.configDone  <= configDone;
            status.authenticationComplete <= authDone;
            status.userMode    <= userMode;
            status.transparent <= userMode && persisted;
            status.pinsReserved <= userMode && persisted;
            portWidth          <= width;
            keySeen            <= portActive;
        end
    end
endmodule

// ===== test/slave_spi_config_port_asserts.sv
`timescale 1ns/1ps
module slave_spi_config_port_asserts
    import sspi_port_pkg::*;
(
    // Clock and reset
    input wire logic                       clk_sys,
    input wire logic                       sys_rst,
    // Pins
    input wire logic                       port_select_n,
    input wire logic [3:0]                 wideDataOe,
    input wire logic                       program_request_n,
    input wire logic                       config_init_status,
    input wire logic                       donePinIn,
    input wire logic                       donePinOe,
    input wire logic                       encryptedStream,
    // Status
    input wire sspi_port_pkg::cfg_status_t status,
    input wire sspi_port_pkg::width_t      portWidth
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_oe_deselect_off: assert property (
        port_select_n [*3] |-> wideDataOe == 4'h0) else $error("output enabled while deselected");
    a_serial_miso_only: assert property (
        portWidth == WIDTH_X1 |-> wideDataOe[0] == 1'b0 && wideDataOe[3:2] == 2'h0)
        else $error("wide line driven in serial width");
    a_width_frame_hold: assert property (
        (!port_select_n) [*4] |-> $stable(portWidth)) else $error("width changed inside a frame");
    a_wide_from_serial: assert property (
        $changed(portWidth) && portWidth != WIDTH_X1 |-> $past(portWidth) == WIDTH_X1)
        else $error("wide width entered from wide width");
    a_done_after_status: assert property (
        $fell(donePinOe) |-> status.configDone && (!encryptedStream || status.authenticationComplete))
        else $error("done released before status bits");
    a_no_wake_held: assert property (
        $rose(status.userMode) |-> $past(donePinIn) && $past(donePinIn, 2))
        else $error("woke up while done held low");
    a_persist_user: assert property (
        status.transparent |-> status.userMode && status.pinsReserved && config_init_status && donePinIn)
        else $error("transparent port outside user mode");
    a_pulse_clears: assert property (
        $fell(program_request_n) ##1 (!program_request_n) [*7]
        |-> ##2 (!status.portActive && portWidth == WIDTH_X1))
        else $error("program pulse did not clear port");
    a_init_released: assert property (
        $rose(config_init_status) |-> program_request_n && $past(program_request_n, 2))
        else $error("init status rose while program held");
endmodule

bind slave_spi_config_port slave_spi_config_port_asserts u_asserts (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .port_select_n(port_select_n),
    .wideDataOe(wideDataOe), .program_request_n(program_request_n),
    .config_init_status(config_init_status), .donePinIn(donePinIn), .donePinOe(donePinOe),
    .encryptedStream(encryptedStream), .status(status), .portWidth(portWidth));

// ===== test/sspi_host_model.sv
`timescale 1ns/1ps
module sspi_host_model (
    // Link toward the port
    output logic            sclk,
    output logic            port_select_n,
    output logic [3:0]      wideDataIn,
    input  wire logic [3:0] wideDataOut,
    input  wire logic [3:0] wideDataOe
);
    logic [39:0] rxBits;
    logic [3:0]  oeSeen;

    initial begin
        sclk = 1'b0;
        port_select_n = 1'b1;
        wideDataIn = 4'h5;
        rxBits = '0;
        oeSeen = 4'h0;
    end

    // Whole bytes only, top line carries the earliest bit
    task automatic xfer(input logic [39:0] bits, input int n, input int lanes);
        int i;
        int k;
        oeSeen = 4'h0;
        // Edges while deselected let the new width cross
        repeat (2) begin
            #3.75 sclk = 1'b1;
            #3.75 sclk = 1'b0;
        end
        #5 port_select_n = 1'b0;
        #5;
        for (i = 0; i < n; i += lanes) begin
            for (k = 0; k < lanes; k++) begin
                wideDataIn[lanes-1-k] = bits[n-1-i-k];
            end
            #3.75 sclk = 1'b1;
            rxBits = {rxBits[38:0], wideDataOut[1]};
            oeSeen = oeSeen | wideDataOe;
            #3.75 sclk = 1'b0;
        end
        #5 port_select_n = 1'b1;
        // Released lines must not keep the last value
        wideDataIn = ~wideDataIn;
    endtask
endmodule

// ===== test/slave_spi_config_port_bench.sv
`timescale 1ns/1ps
module slave_spi_config_port_bench;
    import sspi_port_pkg::*;

    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic program_request_n = 1'b0;
    logic bitstreamComplete = 1'b0;
    logic encryptedStream = 1'b0;
    logic authPass = 1'b0;
    logic reloadRequest = 1'b0;
    logic readCommand = 1'b0;
    logic [7:0] readData = 8'h00;
    persist_t persistBits = {1'b1, WIDTH_X1};
    logic doneHold = 1'b1;
    logic sclk, port_select_n, config_init_status, donePinIn, donePinOe, keySeen;
    logic [3:0] wideDataIn, wideDataOut, wideDataOe;
    cfg_status_t status;
    width_t portWidth;
    int fail_count = 0;
    int checks = 0;

    always #12.5 clk_sys = ~clk_sys;
    // Open-drain pin with pull-up
    assign donePinIn = !(donePinOe || doneHold);

    slave_spi_config_port u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk),
        .port_select_n(port_select_n), .wideDataIn(wideDataIn), .wideDataOut(wideDataOut),
        .wideDataOe(wideDataOe), .program_request_n(program_request_n),
        .config_init_status(config_init_status), .donePinIn(donePinIn), .donePinOe(donePinOe),
        .bitstreamComplete(bitstreamComplete), .encryptedStream(encryptedStream),
        .authPass(authPass), .reloadRequest(reloadRequest), .readCommand(readCommand),
        .readData(readData), .persistBits(persistBits), .status(status),
        .portWidth(portWidth), .keySeen(keySeen));
    sspi_host_model u_host (.sclk(sclk), .port_select_n(port_select_n),
        .wideDataIn(wideDataIn), .wideDataOut(wideDataOut), .wideDataOe(wideDataOe));

    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_bit(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic cmp_width(input string nm, input width_t exp, input width_t got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic cmp_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic cond(input int sel);
        case (sel)
            0: return config_init_status;
            default: return status.userMode;
        endcase
    endfunction

    task automatic wait_until(input int sel, input int lim);
        int i;
        for (i = 0; i < lim && cond(sel) !== 1'b1; i++) @(posedge clk_sys);
        if (cond(sel) !== 1'b1) begin
            fail_count++;
            $display("wrong value wait %0d expected 1 seen 0", sel);
            test_done();
        end
    endtask

    task automatic t_reset_state();
        cmp_width("portWidth", WIDTH_X1, portWidth);
        cmp_bit("portActive", 1'b0, status.portActive);
        cmp_bit("donePinOe", 1'b1, donePinOe);
        cmp_bit("initStatus", 1'b0, config_init_status);
    endtask

    task automatic t_key_early();
        u_host.xfer({8'h00, ACTIVATION_KEY}, 40, 1);
        tick(12);
        cmp_bit("keySeen", 1'b0, keySeen);
        program_request_n <= 1'b1;
        wait_until(0, 200);
    endtask

    task automatic t_activation();
        u_host.xfer({8'h5A, ACTIVATION_KEY ^ 32'h0000_0001}, 40, 1);
        tick(12);
        cmp_bit("keySeen", 1'b0, keySeen);
        u_host.xfer({ACTIVATION_KEY[31:24], ACTIVATION_KEY}, 40, 1);
        tick(12);
        cmp_bit("keySeen", 1'b1, keySeen);
        cmp_bit("portActive", 1'b1, status.portActive);
        cmp_byte("oeSeen", 8'h00, {4'h0, u_host.oeSeen});
    endtask

    task automatic t_read();
        readData <= 8'hA5;
        readCommand <= 1'b1;
        tick(4);
        u_host.xfer(40'h00_0000_0000, 16, 1);
        // Enable crosses in two link edges, so the byte leaves from the second fall
        cmp_byte("readByte", 8'hA5, u_host.rxBits[13:6]);
        cmp_byte("oeSeen", 8'h02, {4'h0, u_host.oeSeen});
        tick(1);
        readCommand <= 1'b0;
        tick(4);
    endtask

    task automatic t_width();
        u_host.xfer({8'h00, CMD_QUAD_ENABLE}, 32, 1);
        tick(12);
        cmp_width("portWidth", WIDTH_X4, portWidth);
        u_host.xfer({8'h00, CMD_DUAL_ENABLE}, 32, 4);
        tick(12);
        cmp_width("portWidth", WIDTH_X4, portWidth);
        u_host.xfer({8'h00, CMD_WIDE_DISABLE}, 32, 4);
        tick(12);
        cmp_width("portWidth", WIDTH_X1, portWidth);
        u_host.xfer({8'h00, CMD_DUAL_ENABLE}, 32, 1);
        tick(12);
        cmp_width("portWidth", WIDTH_X2, portWidth);
        u_host.xfer({8'h00, CMD_QUAD_ENABLE}, 32, 2);
        tick(12);
        cmp_width("portWidth", WIDTH_X2, portWidth);
    endtask

    task automatic t_restore();
        program_request_n <= 1'b0;
        tick(8);
        program_request_n <= 1'b1;
        tick(8);
        cmp_bit("portActive", 1'b0, status.portActive);
        cmp_width("portWidth", WIDTH_X1, portWidth);
        wait_until(0, 200);
        u_host.xfer({8'h00, CMD_QUAD_ENABLE}, 32, 1);
        tick(12);
        reloadRequest <= 1'b1;
        tick(1);
        reloadRequest <= 1'b0;
        tick(12);
        cmp_width("portWidth", WIDTH_X1, portWidth);
        wait_until(0, 200);
    endtask

    task automatic t_wake();
        bitstreamComplete <= 1'b1;
        authPass <= 1'b1;
        tick(STATUS_WAIT_PLAIN_CYC + 100);
        cmp_bit("configDone", 1'b1, status.configDone);
        cmp_bit("authDone", 1'b0, status.authenticationComplete);
        cmp_bit("userMode", 1'b0, status.userMode);
        doneHold <= 1'b0;
        wait_until(1, 100);
        cmp_bit("transparent", 1'b1, status.transparent);
        cmp_bit("pinsReserved", 1'b1, status.pinsReserved);
        u_host.xfer({8'h00, ACTIVATION_KEY}, 40, 1);
        tick(12);
        cmp_bit("keySeen", 1'b0, keySeen);
    endtask

    initial begin
        tick(8);
        sys_rst <= 1'b0;
        tick(2);
        t_reset_state();
        t_key_early();
        t_activation();
        t_read();
        t_width();
        t_restore();
        t_wake();
        test_done();
    end
endmodule
